/* hdl/reset_source_controller.sv */
// How it works
// - Five sources: pin, power-on, brown-out, software, watchdog
// - Power-on resets all; brown-out, watchdog spare debug
// - Pin resets core, peripherals, debug pin configuration
// - Software request resets core, peripherals, not debug
// - Each reset sets its own cause flag
// - Cause flags survive every non-power-on reset
// - Power-on leaves only the power-on flag set
// - Hold reset until power-on detector goes inactive
// - Boot fetches stack pointer, counter, instruction, runs
// - Power-on detector fires whenever i_nrst goes low
// - Stay in reset while pin stays low
// - Read-only identification and capability registers
// - Brown-out resets only when enabled, until recovered
// - Peripheral reset when its bit set then cleared
// - Watchdog reset input resets at once, with no enable
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller
    import reset_source_pkg::*;
#(
    parameter int NUM_SRCR = 3,
    // Identification values are arbitrary
    parameter logic [31:0] IDENT_0 = 32'h1000_0001,
    parameter logic [31:0] IDENT_1 = 32'h2000_0002,
    parameter logic [5*32-1:0] CAPS = {5{32'h0000_0000}}
)
(
    // Clock and power-on reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Board pins, asynchronous
    input wire logic i_ext_rst_n,
    input wire logic i_test_mode_pin_0,
    input wire logic i_test_mode_pin_1,
    // Detectors
    input wire logic i_bod_low,
    input wire logic i_wdt_reset,
    // Core fetch handshake
    input wire logic i_fetch_ack,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // Reset outputs
    output rst_out_s o_rst,
    output logic [NUM_SRCR*DATA_W-1:0] o_periph_rst_n,
    output boot_s o_boot
);

    // Synchronisers; first stages feed only second stages
    logic [1:0] por_q, por_d;
    logic ext_meta_q, ext_q, bod_meta_q, bod_q;
    logic [1:0] tm_meta_q, tm_q;
    logic ext_meta_d, ext_d, bod_meta_d, bod_d;
    logic [1:0] tm_meta_d, tm_d;
    logic por_done;

    always_comb
    begin
        por_d = {por_q[0], 1'b1};
        ext_meta_d = i_ext_rst_n;
        ext_d = ext_meta_q;
        bod_meta_d = i_bod_low;
        bod_d = bod_meta_q;
        tm_meta_d = {i_test_mode_pin_1, i_test_mode_pin_0};
        tm_d = tm_meta_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            por_q <= 2'h0;
            // Pin idles high; a low reset value would log a false pin cause
            ext_meta_q <= 1'b1;
            ext_q <= 1'b1;
            bod_meta_q <= 1'b0;
            bod_q <= 1'b0;
            tm_meta_q <= 2'h0;
            tm_q <= 2'h0;
        end
        else
        begin
            por_q <= por_d;
            ext_meta_q <= ext_meta_d;
            ext_q <= ext_d;
            bod_meta_q <= bod_meta_d;
            bod_q <= bod_d;
            tm_meta_q <= tm_meta_d;
            tm_q <= tm_d;
        end
    end

    assign por_done = por_q[1];

    // Register file
    logic [NUM_CAUSE-1:0] cause_q, cause_d, cause_set;
    logic bor_en_q, bor_en_d;
    logic [DATA_W-1:0] srcr_q [NUM_SRCR];
    logic [DATA_W-1:0] srcr_prev_q [NUM_SRCR];
    logic [NUM_SRCR*DATA_W-1:0] periph_fall;
    logic [DATA_W-1:0] rdata_d;
    logic swreq_wr, cause_clr_wr, bor_hit;

    assign swreq_wr = i_wr && i_addr == OFF_APP_INT_RESET_CTRL && i_wdata[SYSREQ_BIT];
    assign cause_clr_wr = i_wr && i_addr == OFF_RESET_CAUSE;
    assign bor_hit = bod_q && bor_en_q;

    always_comb
    begin
        cause_set = '0;
        cause_set[CAUSE_EXT_BIT] = !ext_q;
        cause_set[CAUSE_BOR_BIT] = bor_hit;
        cause_set[CAUSE_SW_BIT] = swreq_wr;
        cause_set[CAUSE_WDT_BIT] = i_wdt_reset;
        // Write one to clear; a new cause in the same cycle wins
        cause_d = cause_q;
        if (cause_clr_wr)
        begin
            cause_d = cause_q & ~i_wdata[NUM_CAUSE-1:0];
        end
        cause_d = cause_d | cause_set;
        bor_en_d = bor_en_q;
        if (i_wr && i_addr == OFF_POWER_BROWNOUT_CTRL)
        begin
            bor_en_d = i_wdata[BOR_EN_BIT];
        end
    end

    // Only power-on loads the reset values; other resets keep these registers
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cause_q <= CAUSE_RESET;
            bor_en_q <= BOR_EN_RESET;
        end
        else
        begin
            cause_q <= cause_d;
            bor_en_q <= bor_en_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SRCR; g++)
        begin : g_srcr
            logic [DATA_W-1:0] srcr_d;
            always_comb
            begin
                srcr_d = srcr_q[g];
                if (i_wr && i_addr == OFF_PERIPH_RESET_0 + 8'(g * 4))
                begin
                    srcr_d = i_wdata;
                end
            end
            always_ff @(posedge i_ref_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    srcr_q[g] <= PERIPH_RESET_VAL;
                    srcr_prev_q[g] <= PERIPH_RESET_VAL;
                end
                else
                begin
                    srcr_q[g] <= srcr_d;
                    srcr_prev_q[g] <= srcr_q[g];
                end
            end
            assign periph_fall[g*DATA_W +: DATA_W] = srcr_prev_q[g] & ~srcr_q[g];
        end
    endgenerate

    always_comb
    begin
        rdata_d = '0;
        if (i_rd)
        begin
            case (i_addr)
                OFF_RESET_CAUSE: rdata_d = {{(DATA_W-NUM_CAUSE){1'b0}}, cause_q};
                OFF_POWER_BROWNOUT_CTRL: rdata_d[BOR_EN_BIT] = bor_en_q;
                OFF_DEVICE_IDENT_0: rdata_d = IDENT_0;
                OFF_DEVICE_IDENT_1: rdata_d = IDENT_1;
                OFF_TEST_MODE_STATUS: rdata_d[1:0] = tm_q;
                default: rdata_d = '0;
            endcase
            for (int i = 0; i < NUM_SRCR; i++)
            begin
                if (i_addr == OFF_PERIPH_RESET_0 + 8'(i * 4))
                begin
                    rdata_d = srcr_q[i];
                end
            end
            for (int i = 0; i < 5; i++)
            begin
                if (i_addr == OFF_DEVICE_CAP_0 + REG_STRIDE * 8'(i))
                begin
                    rdata_d = CAPS[i*32 +: 32];
                end
            end
        end
    end

    // Reset merge and stretch
    logic [7:0] hold_q, hold_d;
    logic level_src, pulse_src, core_rst_n_d;
    rst_out_s rst_q, rst_d;
    logic [NUM_SRCR*DATA_W-1:0] periph_q, periph_d;

    // Pin and brown-out are levels and hold reset as long as they last
    assign level_src = !ext_q || bor_hit;
    assign pulse_src = swreq_wr || i_wdt_reset;

    always_comb
    begin
        hold_d = hold_q;
        if (!por_done || level_src || pulse_src)
        begin
            hold_d = RST_HOLD_CYC;
        end
        else if (hold_q != 8'h00)
        begin
            hold_d = hold_q - 8'h01;
        end
        core_rst_n_d = por_done && !level_src && !pulse_src && hold_q == 8'h00;
        rst_d.core_n = core_rst_n_d;
        rst_d.dbg_n = por_done;
        rst_d.dbg_pincfg_n = por_done && ext_q;
        periph_d = {(NUM_SRCR*DATA_W){core_rst_n_d}} & ~periph_fall;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            hold_q <= RST_HOLD_CYC;
            rst_q <= '0;
            periph_q <= '0;
        end
        else
        begin
            hold_q <= hold_d;
            rst_q <= rst_d;
            periph_q <= periph_d;
        end
    end

    // Boot fetch sequence after core reset release
    boot_state_e state_q, state_d;
    boot_s boot_q, boot_d;
    logic [DATA_W-1:0] rdata_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            B_HOLD: state_d = B_SP;
            B_SP: if (i_fetch_ack) state_d = B_PC;
            B_PC: if (i_fetch_ack) state_d = B_INSN;
            B_INSN: if (i_fetch_ack) state_d = B_RUN;
            B_RUN: state_d = B_RUN;
            default: state_d = B_HOLD;
        endcase
        if (!rst_q.core_n)
        begin
            state_d = B_HOLD;
        end
        boot_d.fetch_sp = state_d == B_SP;
        boot_d.fetch_pc = state_d == B_PC;
        boot_d.fetch_insn = state_d == B_INSN;
        boot_d.running = state_d == B_RUN;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= B_HOLD;
            boot_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            boot_q <= boot_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rst = rst_q;
    assign o_periph_rst_n = periph_q;
    assign o_boot = boot_q;
    assign o_rdata = rdata_q;

    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_core_release;
        !o_rst.core_n ##1 o_rst.core_n;
    endsequence

    sequence s_sp_done;
        o_boot.fetch_sp && i_fetch_ack;
    endsequence

    a_por_holds_core: assert property (!por_done |=> !o_rst.core_n && !o_rst.dbg_n)
        else $error("core left reset before power-on release");
    a_pin_reset_map: assert property ((!ext_q && por_done) |=>
        (!o_rst.core_n && !o_rst.dbg_pincfg_n && o_rst.dbg_n && o_periph_rst_n == '0))
        else $error("pin reset mapping wrong");
    a_sw_req_hold: assert property (swreq_wr && por_done |=>
        (!o_rst.core_n && o_rst.dbg_n)[*8])
        else $error("software reset not held or touched debug");
    a_cause_set: assert property (swreq_wr |=> cause_q[CAUSE_SW_BIT])
        else $error("software cause flag not set");
    a_cause_sticky: assert property (!cause_clr_wr |=>
        (cause_q & $past(cause_q)) == $past(cause_q))
        else $error("cause flag dropped without clear");
    a_bor_enabled: assert property (bor_hit |=> !o_rst.core_n ##1 !o_rst.core_n)
        else $error("enabled brown-out did not reset");
    a_wdt_reset: assert property (i_wdt_reset && por_done |=>
        !o_rst.core_n && o_rst.dbg_n && cause_q[CAUSE_WDT_BIT])
        else $error("watchdog reset missing");
    a_periph_only: assert property ((|periph_fall) && core_rst_n_d |=>
        o_rst.core_n && ((~o_periph_rst_n & $past(periph_fall)) == $past(periph_fall)))
        else $error("peripheral software reset wrong");
    a_boot_start: assert property (s_core_release |=> o_boot.fetch_sp)
        else $error("boot did not start with stack pointer fetch");
    a_boot_order: assert property (s_sp_done |=> o_boot.fetch_pc || !o_rst.core_n)
        else $error("program counter fetch did not follow");

endmodule
`default_nettype wire

/* hdl/reset_source_pkg.sv */
package reset_source_pkg;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte offsets, one aligned word per register
    localparam logic [7:0] OFF_RESET_CAUSE = 8'h00;
    localparam logic [7:0] OFF_POWER_BROWNOUT_CTRL = 8'h04;
    localparam logic [7:0] OFF_APP_INT_RESET_CTRL = 8'h08;
    localparam logic [7:0] OFF_PERIPH_RESET_0 = 8'h0C;
    localparam logic [7:0] OFF_DEVICE_IDENT_0 = 8'h18;
    localparam logic [7:0] OFF_DEVICE_IDENT_1 = 8'h1C;
    localparam logic [7:0] OFF_DEVICE_CAP_0 = 8'h20;
    localparam logic [7:0] OFF_TEST_MODE_STATUS = 8'h34;
    localparam logic [7:0] REG_STRIDE = 8'h04;

    // Reset cause flag positions
    localparam int NUM_CAUSE = 5;
    localparam int CAUSE_POR_BIT = 0;
    localparam int CAUSE_EXT_BIT = 1;
    localparam int CAUSE_BOR_BIT = 2;
    localparam int CAUSE_SW_BIT = 3;
    localparam int CAUSE_WDT_BIT = 4;
    localparam logic [NUM_CAUSE-1:0] CAUSE_RESET = 5'h01;

    // Control fields
    localparam int BOR_EN_BIT = 1;
    localparam int SYSREQ_BIT = 2;
    localparam logic BOR_EN_RESET = 1'b0;
    localparam logic [DATA_W-1:0] PERIPH_RESET_VAL = 32'h0000_0000;

    // Least hold time of an internal reset after a pulsed source
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_HOLD_NS = 100;
    localparam int RST_HOLD_CYC_I = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] RST_HOLD_CYC = 8'(RST_HOLD_CYC_I);

    typedef struct packed {
        logic core_n;
        logic dbg_n;
        logic dbg_pincfg_n;
    } rst_out_s;

    typedef struct packed {
        logic fetch_sp;
        logic fetch_pc;
        logic fetch_insn;
        logic running;
    } boot_s;

    typedef enum logic [2:0] {
        B_HOLD,
        B_SP,
        B_PC,
        B_INSN,
        B_RUN
    } boot_state_e;

endpackage

/* tb/board_reset_model.sv */
`timescale 1ns/1ps
`default_nettype none
module board_reset_model #(
    parameter int MIN_LOW = 4
)
(
    // Clock and request
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic [7:0] i_low_cyc,
    // Board pins
    output logic o_ext_rst_n,
    output logic o_test_mode_pin_0,
    output logic o_test_mode_pin_1,
    output logic o_busy
);
    int cnt = 0;
    initial o_ext_rst_n = 1'b1;
    assign o_test_mode_pin_0 = 1'b0;
    assign o_test_mode_pin_1 = 1'b0;
    assign o_busy = (cnt != 0);
    // Short requests are stretched to the least legal pulse
    always @(posedge i_ref_clk)
    begin
        if (cnt > 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
                o_ext_rst_n <= 1'b1;
        end
        else if (i_go)
        begin
            o_ext_rst_n <= 1'b0;
            cnt <= (int'(i_low_cyc) < MIN_LOW) ? MIN_LOW : int'(i_low_cyc);
        end
    end
endmodule
`default_nettype wire

/* tb/reset_source_controller_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_bench;
    import reset_source_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_bod_low = 1'b0;
    logic i_wdt_reset = 1'b0;
    logic i_fetch_ack = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic go = 1'b0;
    logic rd_last = 1'b0;
    logic [7:0] low_cyc = 8'h00;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [DATA_W-1:0] i_wdata = 32'h0;
    logic [DATA_W-1:0] o_rdata;
    logic [DATA_W-1:0] v;
    logic [3*DATA_W-1:0] o_periph_rst_n;
    wire logic ext_n;
    wire logic tm0;
    wire logic tm1;
    wire logic busy;
    rst_out_s o_rst;
    boot_s o_boot;
    logic [DATA_W-1:0] exp_q[$];
    int err_total = 0;
    int tests_run = 0;
    int n;

    initial forever #2.5 i_ref_clk = ~i_ref_clk;

    board_reset_model u_board (.i_ref_clk(i_ref_clk), .i_go(go), .i_low_cyc(low_cyc),
        .o_ext_rst_n(ext_n), .o_test_mode_pin_0(tm0), .o_test_mode_pin_1(tm1), .o_busy(busy));

    reset_source_controller u_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ext_rst_n(ext_n),
        .i_test_mode_pin_0(tm0), .i_test_mode_pin_1(tm1), .i_bod_low(i_bod_low),
        .i_wdt_reset(i_wdt_reset), .i_fetch_ack(i_fetch_ack), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rst(o_rst),
        .o_periph_rst_n(o_periph_rst_n), .o_boot(o_boot));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_bit(input string what, input logic e, input logic g);
        check_word(what, {31'h0, e}, {31'h0, g});
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge i_ref_clk) rd_last <= i_rd;
    always @(negedge i_ref_clk)
        if (rd_last === 1'b1)
            check_word("read data", exp_q.pop_front(), o_rdata);

    task automatic boot_walk;
        n = 0;
        while (o_rst.core_n !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        check_bit("core up", 1'b1, o_rst.core_n);
        tick(4);
        check_word("boot", 32'h8, {28'h0, o_boot});
        for (int k = 0; k < 3; k++)
        begin
            @(posedge i_ref_clk) i_fetch_ack <= 1'b1;
            @(posedge i_ref_clk) i_fetch_ack <= 1'b0;
            #1;
            check_word("boot", 32'h4 >> k, {28'h0, o_boot});
        end
    endtask

    task automatic expect_core_only;
        check_bit("core", 1'b0, o_rst.core_n);
        check_bit("debug", 1'b1, o_rst.dbg_n);
        check_word("periph", 32'h0, o_periph_rst_n[31:0]);
    endtask

    initial
    begin
        repeat (4000) @(posedge i_ref_clk);
        err_total++;
        results;
    end

    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(OFF_RESET_CAUSE, 32'h1);
        rd(OFF_DEVICE_IDENT_0, 32'h1000_0001);
        wr(OFF_DEVICE_IDENT_1, 32'hFFFF_FFFF);
        rd(OFF_DEVICE_IDENT_1, 32'h2000_0002);
        rd(OFF_TEST_MODE_STATUS, 32'h0);
        rd(8'h40, 32'h0);
        boot_walk;
        check_bit("debug", 1'b1, o_rst.dbg_n);
        $display("test power-on done");
        wr(OFF_APP_INT_RESET_CTRL, 32'h4);
        #1;
        expect_core_only;
        n = 0;
        while (o_rst.core_n === 1'b0 && n < 100)
        begin
            tick(1);
            n++;
        end
        check_word("hold", {24'h0, RST_HOLD_CYC} + 32'h1, 32'(n));
        boot_walk;
        rd(OFF_RESET_CAUSE, 32'h09);
        $display("test software done");
        @(posedge i_ref_clk) i_wdt_reset <= 1'b1;
        @(posedge i_ref_clk) i_wdt_reset <= 1'b0;
        #1;
        expect_core_only;
        boot_walk;
        rd(OFF_RESET_CAUSE, 32'h19);
        $display("test watchdog done");
        @(posedge i_ref_clk) i_bod_low <= 1'b1;
        tick(10);
        check_bit("core", 1'b1, o_rst.core_n);
        @(posedge i_ref_clk) i_bod_low <= 1'b0;
        wr(OFF_POWER_BROWNOUT_CTRL, 32'h2);
        @(posedge i_ref_clk) i_bod_low <= 1'b1;
        tick(30);
        expect_core_only;
        @(posedge i_ref_clk) i_bod_low <= 1'b0;
        boot_walk;
        rd(OFF_RESET_CAUSE, 32'h1D);
        $display("test brown-out done");
        @(posedge i_ref_clk) go <= 1'b1;
        low_cyc <= 8'd30;
        @(posedge i_ref_clk) go <= 1'b0;
        tick(25);
        expect_core_only;
        check_bit("pin config", 1'b0, o_rst.dbg_pincfg_n);
        boot_walk;
        check_bit("pin config", 1'b1, o_rst.dbg_pincfg_n);
        rd(OFF_RESET_CAUSE, 32'h1F);
        $display("test pin done");
        v = lfsr(32'd69844) | 32'h1;
        wr(OFF_PERIPH_RESET_0, v);
        wr(OFF_PERIPH_RESET_0, 32'h0);
        n = 0;
        for (int k = 0; k < 6; k++)
        begin
            tick(1);
            check_bit("periph hi", 1'b1, &o_periph_rst_n[95:32]);
            check_bit("core", 1'b1, o_rst.core_n);
            if (o_periph_rst_n[31:0] !== 32'hFFFF_FFFF)
            begin
                n++;
                check_word("periph", ~v, o_periph_rst_n[31:0]);
            end
        end
        check_word("periph pulses", 32'h1, 32'(n));
        $display("test peripheral done");
        wr(OFF_RESET_CAUSE, 32'h1F);
        rd(OFF_RESET_CAUSE, 32'h0);
        @(posedge i_ref_clk) i_wdt_reset <= 1'b1;
        @(posedge i_ref_clk) i_wdt_reset <= 1'b0;
        tick(2);
        @(posedge i_ref_clk) i_nrst <= 1'b0;
        tick(2);
        check_word("all reset", 32'h0, {29'h0, o_rst});
        @(posedge i_ref_clk) i_nrst <= 1'b1;
        boot_walk;
        rd(OFF_RESET_CAUSE, 32'h1);
        rd(OFF_POWER_BROWNOUT_CTRL, 32'h0);
        tick(2);
        $display("test second power-on done");
        results;
    end
endmodule
`default_nettype wire
